// [bench/flash_spi_port_assertions.sv]
// concurrent checks on the pins of the serial flash port
`timescale 1ns/1ps
module flash_spi_port_assertions #(
   parameter int ERASE_TIME = 360000,
   parameter int BYTE_TIME = 365,
   parameter int ARM_TIME = 300000,
   parameter logic [7:0] PROTECT_CONFIG = 8'h00
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // serial pins
   input wire logic program_mode_pin_in,
   input wire logic sck_in,
   input wire logic mosi_in,
   input wire logic chip_select_n_in,
   input wire logic miso_out,
   input wire logic miso_oe_out,
   // state
   input wire logic spi_active_out,
   input wire logic [7:0] flash_status_out
);
   default clocking dc @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   int busy_cnt;
   // length of the running sequence; sync latency makes exact end checks fragile
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         busy_cnt <= 0;
      end else begin
         busy_cnt <= flash_status_out[0] ? busy_cnt + 1 : 0;
      end
   end
   AST_OE_WHEN_ACTIVE: assert property (miso_oe_out |-> spi_active_out)
      else $error("miso driven outside programming mode");
   AST_ACTIVE_FOLLOWS_MODE: assert property (program_mode_pin_in [*8] |-> spi_active_out)
      else $error("mode pin high but port inactive");
   AST_LATCH_CLEAR_AT_START: assert property ($past(rst_in) |-> !flash_status_out[5])
      else $error("write latch set after reset");
   AST_SEQ_ON_DESELECT: assert property ($rose(flash_status_out[0]) && spi_active_out |->
      chip_select_n_in && $past(chip_select_n_in, 3))
      else $error("sequence started while selected");
   AST_LATCH_CLEARED_AT_END: assert property ($fell(flash_status_out[0]) && spi_active_out
      |-> !flash_status_out[5])
      else $error("write latch kept after sequence");
   AST_BUSY_LASTS: assert property ($fell(flash_status_out[0]) && spi_active_out
      |-> busy_cnt >= BYTE_TIME)
      else $error("sequence ended too early");
   AST_BUSY_FREEZE: assert property (flash_status_out[0] && $past(flash_status_out[0])
      |-> $stable({flash_status_out[7], flash_status_out[5:3]}))
      else $error("command acted while busy");
   AST_LOCK_STICKY: assert property ($fell(flash_status_out[2]) && $past(spi_active_out)
      |-> $past(flash_status_out[0]))
      else $error("main lock cleared without erase");
endmodule : flash_spi_port_assertions
bind flash_spi_port flash_spi_port_assertions #(.ERASE_TIME(ERASE_TIME), .BYTE_TIME(BYTE_TIME),
   .ARM_TIME(ARM_TIME), .PROTECT_CONFIG(PROTECT_CONFIG)) flash_spi_port_assertions_inst (
   .sys_clk_in(sys_clk_in), .rst_in(rst_in), .program_mode_pin_in(program_mode_pin_in),
   .sck_in(sck_in), .mosi_in(mosi_in), .chip_select_n_in(chip_select_n_in),
   .miso_out(miso_out), .miso_oe_out(miso_oe_out), .spi_active_out(spi_active_out),
   .flash_status_out(flash_status_out));

// [bench/spi_flash_programming_port_tb.sv]
// self-checking bench for the serial flash programming port
`timescale 1ns/1ps
module spi_flash_programming_port_tb;
   localparam int ET = 2000;
   localparam int BT = 300;
   // busy end is seen once per status byte, then that byte and the deselect follow
   localparam int LAG_MIN = 60;
   localparam int LAG_MAX = 190;
   // arbitrary protect configuration
   localparam logic [7:0] PCFG = 8'h5A;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic mode = 1'b0;
   logic sck, mosi, cs_n, miso, oe, act;
   logic [7:0] st;
   logic [7:0] r[$];
   int bad_count = 0;
   int check_count = 0;
   int mem[int];
   always #2.5 clk = ~clk;
   flash_spi_port #(.ERASE_TIME(ET), .BYTE_TIME(BT), .ARM_TIME(20), .PROTECT_CONFIG(PCFG))
   flash_spi_port_inst (.sys_clk_in(clk), .rst_in(rst), .program_mode_pin_in(mode),
      .sck_in(sck), .mosi_in(mosi), .chip_select_n_in(cs_n), .miso_out(miso),
      .miso_oe_out(oe), .spi_active_out(act), .flash_status_out(st));
   spi_master_model spi_master_model_inst (.sck_out(sck), .mosi_out(mosi), .cs_n_out(cs_n),
      .miso_in(miso), .miso_oe_in(oe));
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done
   task automatic chk(input logic [7:0] got, input int exp, input logic [7:0] m);
      check_count++;
      if ((got & m) !== (exp[7:0] & m)) begin
         bad_count++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp[7:0]);
      end
   endtask : chk
   task automatic frame(input logic [7:0] q[$]);
      logic [7:0] b;
      r = {};
      spi_master_model_inst.sel(1'b1);
      foreach (q[i]) begin
         spi_master_model_inst.xfer(q[i], b);
         r.push_back(b);
      end
      spi_master_model_inst.sel(1'b0);
   endtask : frame
   // one selection, status repeated until idle; cycles counted from just after cs rise
   task automatic poll(output logic [7:0] f, output int c);
      realtime t0;
      logic [7:0] b;
      t0 = $realtime;
      spi_master_model_inst.sel(1'b1);
      spi_master_model_inst.xfer(8'h05, b);
      spi_master_model_inst.xfer(8'h00, f);
      b = f;
      for (int i = 0; i < 60 && b[0] !== 1'b0; i++)
         spi_master_model_inst.xfer(8'h00, b);
      spi_master_model_inst.sel(1'b0);
      c = int'(($realtime - t0) / 5.0);
   endtask : poll
   initial begin
      #200us;
      bad_count++;
      test_done();
   end
   initial begin
      logic [7:0] f;
      logic [7:0] d[2];
      int c;
      void'($urandom(32'h5B1318B5));
      repeat (12) @(posedge clk);
      #1 rst = 1'b0;
      @(posedge clk);
      #1 mode = 1'b1;
      repeat (60) @(posedge clk);
      frame('{8'h01, 8'hFF});
      chk(st, 8'h18, 8'hF9);
      frame('{8'h01, 8'h08});
      frame('{8'h06});
      frame('{8'h05, 8'h00});
      chk(r[1], 8'h28, 8'hF9);
      frame('{8'h62});
      poll(f, c);
      chk(f, 1, 8'h01);
      chk(8'(c >= ET + LAG_MIN && c <= ET + LAG_MAX), 1, 8'hFF);
      chk(st, 8'h08, 8'hFF);
      $display("erase all done");
      frame('{8'h01, 8'h00});
      frame('{8'h89, 8'h00});
      chk(r[1], PCFG, 8'hFF);
      frame('{8'h06});
      frame('{8'h04});
      chk(st, 0, 8'hFF);
      frame('{8'h02, 8'hFE, 8'h3F, 8'hAA});
      chk(st, 0, 8'hFF);
      $display("status commands done");
      d[0] = 8'($urandom);
      d[1] = 8'($urandom);
      frame('{8'h06});
      frame('{8'h02, 8'hFE, 8'h3F, d[0], d[1]});
      mem[16382] = d[0];
      mem[16383] = d[1];
      poll(f, c);
      chk(f, 1, 8'h01);
      chk(8'(c >= 3 * BT + LAG_MIN && c <= 3 * BT + LAG_MAX), 1, 8'hFF);
      chk(st, 0, 8'hFF);
      frame('{8'h03, 8'hFE, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00});
      for (int i = 0; i < 4; i++)
         chk(r[3 + i], mem.exists((16382 + i) % 16384) ? mem[(16382 + i) % 16384] : 255,
            8'hFF);
      $display("program and read done");
      frame('{8'h06});
      frame('{8'h52, 8'h1F});
      // status write while erasing must be ignored
      frame('{8'h01, 8'h18});
      poll(f, c);
      chk(st, 0, 8'hFF);
      frame('{8'h03, 8'hFE, 8'h3F, 8'h00, 8'h00});
      for (int i = 3; i < 5; i++)
         chk(r[i], 255, 8'hFF);
      $display("page erase done");
      frame('{8'h85});
      chk(st, 8'h04, 8'hFF);
      frame('{8'h03, 8'h00, 8'h00, 8'h00});
      chk(r[3], 0, 8'hFF);
      frame('{8'h06});
      frame('{8'h52, 8'h00});
      chk(st, 0, 8'h01);
      frame('{8'h84});
      frame('{8'h86});
      chk(st, 8'hA6, 8'hFF);
      $display("read lock done");
      @(posedge clk);
      #1 rst = 1'b1;
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      repeat (60) @(posedge clk);
      chk(st, 8'h06, 8'hFF);
      $display("restart done");
      test_done();
   end
endmodule : spi_flash_programming_port_tb

// [bench/spi_master_model.sv]
// programmer model: mode 0 frames, clock idles low between frames
`timescale 1ns/1ps
module spi_master_model (
   // serial pins
   output logic sck_out,
   output logic mosi_out,
   output logic cs_n_out,
   input wire logic miso_in,
   input wire logic miso_oe_in
);
   logic last;
   // a released line must not repeat its old bit
   wire logic line = miso_oe_in ? miso_in : ~last;
   initial begin
      sck_out = 1'b0;
      mosi_out = 1'b0;
      cs_n_out = 1'b1;
      last = 1'b0;
   end
   task automatic sel(input logic on);
      #48 cs_n_out = !on;
      #48;
   endtask : sel
   // sampled early in the high phase: reply bits move a synchroniser delay after each edge
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         mosi_out = tx[i];
         #24 sck_out = 1'b1;
         #10 rx[i] = line;
         last = line;
         #14 sck_out = 1'b0;
      end
   endtask : xfer
endmodule : spi_master_model

// [common/flash_port_pkg.sv]
// shared constants and types for the serial flash programming port
package flash_port_pkg;
   // opcodes
   localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
   localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_PROGRAM = 8'h02;
   localparam logic [7:0] OP_ERASE_PAGE = 8'h52;
   localparam logic [7:0] OP_ERASE_ALL = 8'h62;
   localparam logic [7:0] OP_PROTECT_READ = 8'h89;
   localparam logic [7:0] OP_INFOPAGE_LOCK = 8'h84;
   localparam logic [7:0] OP_MAIN_LOCK = 8'h85;
   localparam logic [7:0] OP_DEBUG_ENABLE = 8'h86;
   // flash_status field positions
   localparam int BIT_BUSY = 0;
   localparam int BIT_INFO_LOCK = 1;
   localparam int BIT_MAIN_LOCK = 2;
   localparam int BIT_INFO_SEL = 3;
   localparam int BIT_WRITE_LATCH = 5;
   localparam int BIT_DEBUG_ON = 7;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   // status bits that the status write command may change
   localparam logic [7:0] STATUS_WRITE_MASK = 8'h18;
   // infopage lock byte offsets and erased value
   localparam logic [8:0] INFO_INFO_LOCK = 9'h022;
   localparam logic [8:0] INFO_MAIN_LOCK = 9'h023;
   localparam logic [8:0] INFO_DEBUG = 9'h024;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] CLEARED_BYTE = 8'h00;
   // timing at the crystal clock, which is the block clock here
   localparam int ERASE_CYCLES = 360000;
   localparam int PROGRAM_BYTE_CYCLES = 365;
   localparam real ARM_DELAY_MS = 1.5;
   localparam real CLK_MHZ = 200.0;
   localparam int ARM_CYCLES = int'(ARM_DELAY_MS * 1000.0 * CLK_MHZ);
   localparam int MAX_PROGRAM_BYTES = 256;
   localparam int PAGE_COUNT = 32;
   localparam int PAGE_BYTES = 512;
   localparam int INFO_BYTES = 512;
   // synchronised serial pins
   typedef struct packed {
      logic sck;
      logic mosi;
      logic cs_n;
      logic mode;
   } spi_pins_s;
   typedef enum {SEQ_IDLE, SEQ_INIT, SEQ_PROGRAM, SEQ_ERASE_PAGE, SEQ_ERASE_ALL,
      SEQ_LOCK_WRITE} seq_e;
endpackage : flash_port_pkg

// [hw/flash_spi_port.sv]
// serial programming port with flash array and self-timed sequencer
`timescale 1ns/1ps
// Notes on behaviour
// - mode pin high turns pins into slave
// - decode latch set, latch clear, status read
// - status write without debug bit; read, program
// - page erase, full erase, protect config read
// - lock commands set status bits 1,2,7
// - command first, low byte first, msb first
// - write latch clear at power-up
// - status read repeats every following byte
// - read sends opcode, two address bytes
// - read address increments and wraps
// - read data only when unlocked
// - program up to 256 bytes, starts on deselect
// - busy ignores all but status read and the page number byte of page erase
// - sequence end clears write latch
// - page erase number 0-31, infopage if selected
// - full erase includes infopage if selected
// - lock commands clear infopage bytes 0x22-0x24
// - lock bits loaded from infopage at start
// - main lock blocks program, page erase
// - locks persist until flash erased
// - full erase lasts 360000 cycles
// - program lasts (n+1) times 365 cycles
module flash_spi_port #(
   parameter int ERASE_TIME = flash_port_pkg::ERASE_CYCLES,
   parameter int BYTE_TIME = flash_port_pkg::PROGRAM_BYTE_CYCLES,
   parameter int ARM_TIME = flash_port_pkg::ARM_CYCLES,
   parameter logic [7:0] PROTECT_CONFIG = 8'h00
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // programming pins
   input wire logic program_mode_pin_in,
   input wire logic sck_in,
   input wire logic mosi_in,
   input wire logic chip_select_n_in,
   output logic miso_out,
   output logic miso_oe_out,
   // state for the rest of the chip
   output logic spi_active_out,
   output logic [7:0] flash_status_out
);
   localparam int MAIN_BYTES = flash_port_pkg::PAGE_COUNT * flash_port_pkg::PAGE_BYTES;

   flash_port_pkg::spi_pins_s pins;
   logic [7:0] main_mem [MAIN_BYTES];
   logic [7:0] info_mem [flash_port_pkg::INFO_BYTES];
   logic [7:0] program_mode_pin_buf [flash_port_pkg::MAX_PROGRAM_BYTES];

   pin_sync #(.RESET_VALUE(1'b0)) u_mode (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .pin_in(program_mode_pin_in), .level_out(pins.mode));
   pin_sync #(.RESET_VALUE(1'b0)) u_sck (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .pin_in(sck_in), .level_out(pins.sck));
   pin_sync #(.RESET_VALUE(1'b0)) u_mosi (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .pin_in(mosi_in), .level_out(pins.mosi));
   pin_sync #(.RESET_VALUE(1'b1)) u_cs (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .pin_in(chip_select_n_in), .level_out(pins.cs_n));

   logic sck_prev_reg;
   logic cs_prev_reg;
   logic [31:0] arm_cnt_reg;
   logic armed;
   logic selected;
   logic sck_rise;
   logic sck_fall;
   logic cs_rise;

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sck_prev_reg <= 1'b0;
         cs_prev_reg <= 1'b1;
      end else begin
         sck_prev_reg <= pins.sck;
         cs_prev_reg <= pins.cs_n;
      end
   end

   // port stays dead until the programmer's settling wait has passed
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         arm_cnt_reg <= 32'h0;
      end else if (!pins.mode) begin
         arm_cnt_reg <= 32'h0;
      end else if (arm_cnt_reg < 32'(ARM_TIME)) begin
         arm_cnt_reg <= arm_cnt_reg + 32'h1;
      end
   end

   assign armed = pins.mode && (arm_cnt_reg >= 32'(ARM_TIME));
   assign selected = armed && !pins.cs_n;
   assign sck_rise = selected && pins.sck && !sck_prev_reg;
   assign sck_fall = selected && !pins.sck && sck_prev_reg;
   assign cs_rise = armed && pins.cs_n && !cs_prev_reg;
   assign spi_active_out = pins.mode;

   // byte shifter
   logic [2:0] bit_cnt_reg;
   logic [7:0] shift_in_reg;
   logic [7:0] shift_out_reg;
   logic [8:0] byte_cnt_reg;
   logic [7:0] opcode_reg;
   logic [15:0] addr_reg;
   logic byte_done;
   logic [7:0] rx_byte;
   logic [7:0] status_reg;
   logic [7:0] tx_next;
   logic busy;
   flash_port_pkg::seq_e seq_reg;

   assign rx_byte = {shift_in_reg[6:0], pins.mosi};
   assign byte_done = sck_rise && (bit_cnt_reg == 3'd7);
   assign busy = (seq_reg != flash_port_pkg::SEQ_IDLE);

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         bit_cnt_reg <= 3'd0;
         shift_in_reg <= 8'h00;
         byte_cnt_reg <= 9'h000;
      end else if (!selected) begin
         bit_cnt_reg <= 3'd0;
         byte_cnt_reg <= 9'h000;
      end else if (sck_rise) begin
         shift_in_reg <= rx_byte;
         bit_cnt_reg <= bit_cnt_reg + 3'd1;
         if (bit_cnt_reg == 3'd7 && byte_cnt_reg != 9'h1FF) begin
            byte_cnt_reg <= byte_cnt_reg + 9'h001;
         end
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         opcode_reg <= 8'h00;
      end else if (!selected) begin
         opcode_reg <= 8'h00;
      end else if (byte_done && byte_cnt_reg == 9'h000) begin
         opcode_reg <= rx_byte;
      end
   end

   // address arrives low byte first, then advances per data byte
   logic [15:0] addr_wrap;
   assign addr_wrap = (addr_reg == 16'(MAIN_BYTES - 1)) ? 16'h0000 : addr_reg + 16'h0001;
   logic [8:0] program_mode_pin_cnt_reg;
   logic [15:0] program_mode_pin_start_reg;

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         addr_reg <= 16'h0000;
      end else if (byte_done && byte_cnt_reg == 9'h001) begin
         addr_reg <= {8'h00, rx_byte};
      end else if (byte_done && byte_cnt_reg == 9'h002) begin
         addr_reg <= {rx_byte, addr_reg[7:0]};
      end else if (byte_done && byte_cnt_reg > 9'h002) begin
         addr_reg <= addr_wrap;
      end
   end

   // program data collects in a buffer until deselect
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         program_mode_pin_cnt_reg <= 9'h000;
      end else if (selected && byte_cnt_reg == 9'h000 && !busy) begin
         // a status poll during the sequence must not shorten it
         program_mode_pin_cnt_reg <= 9'h000;
      end else if (byte_done && !busy && opcode_reg == flash_port_pkg::OP_PROGRAM
            && byte_cnt_reg > 9'h002 && program_mode_pin_cnt_reg < 9'(flash_port_pkg::MAX_PROGRAM_BYTES)) begin
         program_mode_pin_cnt_reg <= program_mode_pin_cnt_reg + 9'h001;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (byte_done && !busy && opcode_reg == flash_port_pkg::OP_PROGRAM
            && byte_cnt_reg > 9'h002 && program_mode_pin_cnt_reg < 9'(flash_port_pkg::MAX_PROGRAM_BYTES)) begin
         program_mode_pin_buf[program_mode_pin_cnt_reg[7:0]] <= rx_byte;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         program_mode_pin_start_reg <= 16'h0000;
      end else if (byte_done && byte_cnt_reg == 9'h002 && !busy) begin
         program_mode_pin_start_reg <= {rx_byte, addr_reg[7:0]};
      end
   end

   // answer byte loaded at each byte boundary, shifted msb first
   logic reads_open;
   logic [8:0] info_rd;
   assign reads_open = !status_reg[flash_port_pkg::BIT_MAIN_LOCK]
      && !status_reg[flash_port_pkg::BIT_INFO_LOCK];
   assign info_rd = addr_wrap[8:0];
   always_comb begin
      tx_next = 8'h00;
      if (byte_cnt_reg == 9'h000 && rx_byte == flash_port_pkg::OP_STATUS_READ) begin
         tx_next = status_reg;
      end else if (byte_cnt_reg == 9'h000 && rx_byte == flash_port_pkg::OP_PROTECT_READ
            && !busy) begin
         tx_next = PROTECT_CONFIG;
      end else if (opcode_reg == flash_port_pkg::OP_STATUS_READ) begin
         tx_next = status_reg;
      end else if (opcode_reg == flash_port_pkg::OP_READ && !busy && reads_open) begin
         if (byte_cnt_reg == 9'h002) begin
            if (status_reg[flash_port_pkg::BIT_INFO_SEL]) begin
               tx_next = info_mem[{rx_byte[0], addr_reg[7:0]}];
            end else begin
               tx_next = main_mem[14'({rx_byte, addr_reg[7:0]})];
            end
         end else if (byte_cnt_reg > 9'h002) begin
            if (status_reg[flash_port_pkg::BIT_INFO_SEL]) begin
               tx_next = info_mem[info_rd];
            end else begin
               tx_next = main_mem[14'(addr_wrap)];
            end
         end
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         shift_out_reg <= 8'h00;
      end else if (!selected) begin
         shift_out_reg <= 8'h00;
      end else if (byte_done) begin
         shift_out_reg <= tx_next;
      end else if (sck_fall && bit_cnt_reg != 3'd0) begin
         shift_out_reg <= {shift_out_reg[6:0], 1'b0};
      end
   end

   assign miso_out = shift_out_reg[7];
   assign miso_oe_out = selected;
   assign flash_status_out = status_reg;

   // decoded action on deselect or on a finished command byte
   logic cmd_byte;
   logic may_write;
   logic [31:0] seq_cnt_reg;
   logic [31:0] seq_len_reg;
   logic [8:0] seq_idx_reg;
   logic [1:0] lock_kind_reg;
   logic info_target_reg;
   logic [4:0] page_reg;

   assign cmd_byte = byte_done && byte_cnt_reg == 9'h000 && !busy;
   assign may_write = status_reg[flash_port_pkg::BIT_WRITE_LATCH]
      && !status_reg[flash_port_pkg::BIT_MAIN_LOCK];

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         page_reg <= 5'd0;
      end else if (byte_done && byte_cnt_reg == 9'h001 && opcode_reg == flash_port_pkg::OP_ERASE_PAGE) begin
         page_reg <= rx_byte[4:0];
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         seq_reg <= flash_port_pkg::SEQ_INIT;
         seq_cnt_reg <= 32'h0;
         seq_len_reg <= 32'h0;
         seq_idx_reg <= 9'h000;
         lock_kind_reg <= 2'd0;
         info_target_reg <= 1'b0;
      end else begin
         case (seq_reg)
            flash_port_pkg::SEQ_IDLE: begin
               seq_cnt_reg <= 32'h0;
               seq_idx_reg <= 9'h000;
               info_target_reg <= status_reg[flash_port_pkg::BIT_INFO_SEL];
               if (cmd_byte && rx_byte == flash_port_pkg::OP_INFOPAGE_LOCK) begin
                  lock_kind_reg <= 2'd0;
                  seq_reg <= flash_port_pkg::SEQ_LOCK_WRITE;
               end else if (cmd_byte && rx_byte == flash_port_pkg::OP_MAIN_LOCK) begin
                  lock_kind_reg <= 2'd1;
                  seq_reg <= flash_port_pkg::SEQ_LOCK_WRITE;
               end else if (cmd_byte && rx_byte == flash_port_pkg::OP_DEBUG_ENABLE) begin
                  lock_kind_reg <= 2'd2;
                  seq_reg <= flash_port_pkg::SEQ_LOCK_WRITE;
               end else if (cs_rise && opcode_reg == flash_port_pkg::OP_PROGRAM
                     && may_write && program_mode_pin_cnt_reg != 9'h000) begin
                  seq_len_reg <= (32'(program_mode_pin_cnt_reg) + 32'h1) * 32'(BYTE_TIME);
                  seq_reg <= flash_port_pkg::SEQ_PROGRAM;
               end else if (cs_rise && opcode_reg == flash_port_pkg::OP_ERASE_PAGE && may_write
                     && byte_cnt_reg >= 9'h002) begin
                  seq_len_reg <= 32'(ERASE_TIME);
                  seq_reg <= flash_port_pkg::SEQ_ERASE_PAGE;
               end else if (cs_rise && opcode_reg == flash_port_pkg::OP_ERASE_ALL
                     && status_reg[flash_port_pkg::BIT_WRITE_LATCH]) begin
                  seq_len_reg <= 32'(ERASE_TIME);
                  seq_reg <= flash_port_pkg::SEQ_ERASE_ALL;
               end
            end
            flash_port_pkg::SEQ_INIT, flash_port_pkg::SEQ_LOCK_WRITE: begin
               seq_reg <= flash_port_pkg::SEQ_IDLE;
            end
            default: begin
               // array work steps one byte index per cycle inside the timed window
               if (seq_idx_reg != 9'h1FF) begin
                  seq_idx_reg <= seq_idx_reg + 9'h001;
               end
               seq_cnt_reg <= seq_cnt_reg + 32'h1;
               if (seq_cnt_reg + 32'h1 >= seq_len_reg) begin
                  seq_reg <= flash_port_pkg::SEQ_IDLE;
               end
            end
         endcase
      end
   end

   // array writes; erase all walks pages in parallel per byte index
   always_ff @(posedge sys_clk_in) begin
      if (seq_reg == flash_port_pkg::SEQ_LOCK_WRITE) begin
         info_mem[9'(flash_port_pkg::INFO_INFO_LOCK + 9'(lock_kind_reg))]
            <= flash_port_pkg::CLEARED_BYTE;
      end else if (seq_reg == flash_port_pkg::SEQ_PROGRAM
            && seq_idx_reg < program_mode_pin_cnt_reg) begin
         if (info_target_reg) begin
            info_mem[9'(program_mode_pin_start_reg + 16'(seq_idx_reg))] <= info_mem[9'(program_mode_pin_start_reg
               + 16'(seq_idx_reg))] & program_mode_pin_buf[seq_idx_reg[7:0]];
         end else begin
            main_mem[14'(program_mode_pin_start_reg + 16'(seq_idx_reg))] <= main_mem[14'(program_mode_pin_start_reg
               + 16'(seq_idx_reg))] & program_mode_pin_buf[seq_idx_reg[7:0]];
         end
      end else if (seq_reg == flash_port_pkg::SEQ_ERASE_PAGE
            && seq_cnt_reg < 32'(flash_port_pkg::PAGE_BYTES)) begin
         // index saturates at the last byte, so the elapsed count ends the walk
         if (info_target_reg) begin
            info_mem[seq_idx_reg] <= flash_port_pkg::ERASED_BYTE;
         end else begin
            main_mem[{page_reg, seq_idx_reg}] <= flash_port_pkg::ERASED_BYTE;
         end
      end else if (seq_reg == flash_port_pkg::SEQ_ERASE_ALL
            && seq_cnt_reg < 32'(flash_port_pkg::PAGE_BYTES)) begin
         for (int p = 0; p < flash_port_pkg::PAGE_COUNT; p++) begin
            main_mem[{5'(p), seq_idx_reg}] <= flash_port_pkg::ERASED_BYTE;
         end
         if (info_target_reg) begin
            info_mem[seq_idx_reg] <= flash_port_pkg::ERASED_BYTE;
         end
      end
   end

   // status register
   logic seq_end;
   assign seq_end = (seq_reg == flash_port_pkg::SEQ_PROGRAM
      || seq_reg == flash_port_pkg::SEQ_ERASE_PAGE || seq_reg == flash_port_pkg::SEQ_ERASE_ALL)
      && (seq_cnt_reg + 32'h1 >= seq_len_reg);

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         status_reg <= flash_port_pkg::STATUS_RESET;
      end else begin
         status_reg[flash_port_pkg::BIT_BUSY] <= busy && !seq_end
            && seq_reg != flash_port_pkg::SEQ_LOCK_WRITE;
         if (seq_reg == flash_port_pkg::SEQ_INIT) begin
            status_reg[flash_port_pkg::BIT_INFO_LOCK] <=
               info_mem[flash_port_pkg::INFO_INFO_LOCK] != flash_port_pkg::ERASED_BYTE;
            status_reg[flash_port_pkg::BIT_MAIN_LOCK] <=
               info_mem[flash_port_pkg::INFO_MAIN_LOCK] != flash_port_pkg::ERASED_BYTE;
         end else if (seq_end) begin
            status_reg[flash_port_pkg::BIT_WRITE_LATCH] <= 1'b0;
            if (seq_reg == flash_port_pkg::SEQ_ERASE_ALL) begin
               status_reg[flash_port_pkg::BIT_MAIN_LOCK] <= 1'b0;
               if (info_target_reg) begin
                  status_reg[flash_port_pkg::BIT_INFO_LOCK] <= 1'b0;
               end
            end
         end else if (cmd_byte) begin
            if (rx_byte == flash_port_pkg::OP_SET_WRITE_LATCH) begin
               status_reg[flash_port_pkg::BIT_WRITE_LATCH] <= 1'b1;
            end else if (rx_byte == flash_port_pkg::OP_CLEAR_WRITE_LATCH) begin
               status_reg[flash_port_pkg::BIT_WRITE_LATCH] <= 1'b0;
            end else if (rx_byte == flash_port_pkg::OP_INFOPAGE_LOCK) begin
               status_reg[flash_port_pkg::BIT_INFO_LOCK] <= 1'b1;
            end else if (rx_byte == flash_port_pkg::OP_MAIN_LOCK) begin
               status_reg[flash_port_pkg::BIT_MAIN_LOCK] <= 1'b1;
            end else if (rx_byte == flash_port_pkg::OP_DEBUG_ENABLE) begin
               status_reg[flash_port_pkg::BIT_DEBUG_ON] <= 1'b1;
            end
         end else if (byte_done && !busy && byte_cnt_reg == 9'h001
               && opcode_reg == flash_port_pkg::OP_STATUS_WRITE) begin
            // debug bit and locks stay out of reach of this command
            status_reg <= (status_reg & ~flash_port_pkg::STATUS_WRITE_MASK)
               | (rx_byte & flash_port_pkg::STATUS_WRITE_MASK);
         end
      end
   end
endmodule : flash_spi_port

// [hw/pin_sync.sv]
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module pin_sync #(
   parameter logic RESET_VALUE = 1'b0
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // pin and filtered level
   input wire logic pin_in,
   output logic level_out
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s1_reg <= RESET_VALUE;
         s2_reg <= RESET_VALUE;
         s3_reg <= RESET_VALUE;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // change counts once the last two stages agree
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         level_out <= RESET_VALUE;
      end else if (s2_reg == s3_reg) begin
         level_out <= s3_reg;
      end
   end
endmodule : pin_sync
